//--- include/rtdc_cfg.svh
`ifndef RTDC_CFG_SVH
`define RTDC_CFG_SVH
// ----------------------------------------
// nominal timing figures
// ----------------------------------------
`define RTDC_CLK_MHZ          25
`define RTDC_ACT_US           5000
`define RTDC_SLEEP_US         25000
`define RTDC_BLINK_US         60000
`define RTDC_DET_START_US     3000
`define RTDC_DET_END_US       5000
`define RTDC_START_US         100
// on-time law in nanoseconds: slope per megaohm, offset
`define RTDC_TON_SLOPE_NS     3860
`define RTDC_TON_OFS_NS       140
// derived cycle counts
`define RTDC_CYC(us)          ((us) * `RTDC_CLK_MHZ)
`define RTDC_ACT_CYC          `RTDC_CYC(`RTDC_ACT_US)
`define RTDC_SLEEP_CYC        `RTDC_CYC(`RTDC_SLEEP_US)
`define RTDC_BLINK_HALF_CYC   (`RTDC_CYC(`RTDC_BLINK_US) / 2)
`define RTDC_DET_START_CYC    `RTDC_CYC(`RTDC_DET_START_US)
`define RTDC_DET_END_CYC      `RTDC_CYC(`RTDC_DET_END_US)
`define RTDC_START_CYC        `RTDC_CYC(`RTDC_START_US)
`define RTDC_NS_PER_CYC       40
// peak difference that counts as a change, in sense code units
`define RTDC_PEAK_DELTA       4
`endif

//--- include/rtdc_pkg.sv
package rtdc_pkg;
  typedef enum logic [4:0] {
    RTDC_ST_IDLE  = 5'b00001,
    RTDC_ST_ON    = 5'b00010,
    RTDC_ST_MEAS  = 5'b00100,
    RTDC_ST_HOLD  = 5'b01000,
    RTDC_ST_REST  = 5'b10000
  } rtdc_drv_t;
endpackage

//--- rtl/rtdc_ctrl.sv
`timescale 1ns/1ps
// Function
// - after undervoltage release and start-up delay, gate goes high and oscillation starts.
// - gate stays high for exactly one on_time, then goes low.
// - on_time equals 3.86 us per megaohm plus 0.14 us.
// - measure off_hold_time to sense rise, then hold low same time after fall.
// - after off_hold_time, gate goes high again; cycle repeats while enabled.
// - active and sleep windows alternate; continuous mode oscillates through both.
// - intermittent mode oscillates only in active window, gate low in sleep.
// - 3 to 5 ms into active window, successive sense peaks are compared.
// - no peak change means non-detection and intermittent mode.
// - peak change means detection and continuous mode.
// - undervoltage detect enters standby: all halted, gate low, status floats.
// - standby entered at detect level, left only at release level.
// - thermal trip latches gate low; other functions keep running.
// - thermal latch clears only through undervoltage reset.
// - continuous mode drives status low, LED lit.
// - intermittent mode releases status, LED dark.
// - thermal protection blinks status with blink_period.
`include "rtdc_cfg.svh"
module rtdc_ctrl
  import rtdc_pkg::*;
#(
  parameter int ACT_CYC       = `RTDC_ACT_CYC,
  parameter int SLEEP_CYC     = `RTDC_SLEEP_CYC,
  parameter int BLINK_HALF    = `RTDC_BLINK_HALF_CYC,
  parameter int DET_START     = `RTDC_DET_START_CYC,
  parameter int DET_END       = `RTDC_DET_END_CYC,
  parameter int START_CYC     = `RTDC_START_CYC,
  parameter int PEAK_W        = 8,
  parameter int RES_W         = 12
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              uv_detect_in,
  input  wire logic              uv_release_in,
  input  wire logic              sense_above_supply_in,
  input  wire logic              thermal_trip_in,
  input  wire logic [PEAK_W-1:0] resonance_peak_in,
  input  wire logic [RES_W-1:0]  on_time_resistor_value,
  output logic                   gate_drive_out,
  output logic                   status_out,
  output logic                   status_oe
);

  localparam int TW = 24;
  localparam int CW = 32;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // resistor value in kiloohm -> on-time cycles, rounded up, min one
  function automatic logic [TW-1:0] ton_cycles(input logic [RES_W-1:0] r_kohm);
    logic [CW-1:0] ns;
    logic [CW-1:0] cyc;
    ns  = (CW'(r_kohm) * CW'(`RTDC_TON_SLOPE_NS) + CW'(999)) / CW'(1000)
          + CW'(`RTDC_TON_OFS_NS);
    cyc = (ns + CW'(`RTDC_NS_PER_CYC - 1)) / CW'(`RTDC_NS_PER_CYC);
    if (cyc == '0) begin
      cyc = CW'(1);
    end
    return cyc[TW-1:0];
  endfunction

  function automatic logic [PEAK_W-1:0] absdiff(input logic [PEAK_W-1:0] a,
                                                input logic [PEAK_W-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [3:0] s1_ff, s2_ff;
  logic [3:0] nxt_s1, nxt_s2;
  logic [PEAK_W-1:0] pk1_ff, pk2_ff;
  logic [PEAK_W-1:0] nxt_pk1, nxt_pk2;

  always_comb begin
    nxt_s1  = {thermal_trip_in, sense_above_supply_in, uv_release_in, uv_detect_in};
    nxt_s2  = s1_ff;
    nxt_pk1 = resonance_peak_in;
    nxt_pk2 = pk1_ff;
  end

  // only the second stage is read below
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_ff  <= 4'h0;
      s2_ff  <= 4'h0;
      pk1_ff <= '0;
      pk2_ff <= '0;
    end else begin
      s1_ff  <= nxt_s1;
      s2_ff  <= nxt_s2;
      pk1_ff <= nxt_pk1;
      pk2_ff <= nxt_pk2;
    end
  end

  logic uv_det, uv_rel, ring_hi, hot_trip;
  assign uv_det   = s2_ff[0];
  assign uv_rel   = s2_ff[1];
  assign ring_hi  = s2_ff[2];
  assign hot_trip = s2_ff[3];

  // ----------------------------------------
  // undervoltage, start-up, thermal latch
  // ----------------------------------------
  logic          run_ff, nxt_run;
  logic          stby_ff, nxt_stby;
  logic [CW-1:0] st_cnt_ff, nxt_st_cnt;
  logic          hot_ff, nxt_hot;
  logic          ring_d_ff, nxt_ring_d;

  always_comb begin
    nxt_stby   = stby_ff;
    nxt_run    = run_ff;
    nxt_st_cnt = st_cnt_ff;
    nxt_hot    = hot_ff;
    nxt_ring_d = ring_hi;
    if (uv_det) begin
      nxt_stby   = 1'b1;
      nxt_run    = 1'b0;
      nxt_st_cnt = '0;
      nxt_hot    = 1'b0;
    end else if (stby_ff) begin
      if (uv_rel) begin
        nxt_stby = 1'b0;
      end
    end else if (!run_ff) begin
      if (st_cnt_ff >= CW'(START_CYC - 1)) begin
        nxt_run = 1'b1;
      end else begin
        nxt_st_cnt = st_cnt_ff + CW'(1);
      end
    end
    if (!uv_det && !stby_ff && hot_trip) begin
      nxt_hot = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stby_ff   <= 1'b1;
      run_ff    <= 1'b0;
      st_cnt_ff <= '0;
      hot_ff    <= 1'b0;
      ring_d_ff <= 1'b0;
    end else begin
      stby_ff   <= nxt_stby;
      run_ff    <= nxt_run;
      st_cnt_ff <= nxt_st_cnt;
      hot_ff    <= nxt_hot;
      ring_d_ff <= nxt_ring_d;
    end
  end

  // ----------------------------------------
  // windows, reception detection, blink
  // ----------------------------------------
  logic          sleep_ff, nxt_sleep;
  logic [CW-1:0] win_ff, nxt_win;
  logic          cont_ff, nxt_cont;
  logic          chg_ff, nxt_chg;
  logic          havepk_ff, nxt_havepk;
  logic [PEAK_W-1:0] lastpk_ff, nxt_lastpk;
  logic [CW-1:0] blk_cnt_ff, nxt_blk_cnt;
  logic          blk_ff, nxt_blk;
  logic          ring_rise;
  logic          in_det;

  assign ring_rise = ring_hi & ~ring_d_ff;
  assign in_det  = run_ff && !sleep_ff && win_ff >= CW'(DET_START) && win_ff < CW'(DET_END);

  always_comb begin
    nxt_sleep   = sleep_ff;
    nxt_win     = win_ff + CW'(1);
    nxt_cont    = cont_ff;
    nxt_chg     = chg_ff;
    nxt_havepk  = havepk_ff;
    nxt_lastpk  = lastpk_ff;
    nxt_blk_cnt = blk_cnt_ff + CW'(1);
    nxt_blk     = blk_ff;
    if (!run_ff) begin
      nxt_sleep  = 1'b0;
      nxt_win    = '0;
      nxt_cont   = 1'b0;
      nxt_chg    = 1'b0;
      nxt_havepk = 1'b0;
    end else if (!sleep_ff && win_ff >= CW'(ACT_CYC - 1)) begin
      nxt_sleep = 1'b1;
      nxt_win   = '0;
    end else if (sleep_ff && win_ff >= CW'(SLEEP_CYC - 1)) begin
      nxt_sleep  = 1'b0;
      nxt_win    = '0;
      nxt_chg    = 1'b0;
      nxt_havepk = 1'b0;
    end
    // peaks sampled at each sense rise inside the detection interval
    if (run_ff && in_det && ring_rise) begin
      nxt_havepk = 1'b1;
      nxt_lastpk = pk2_ff;
      if (havepk_ff && absdiff(pk2_ff, lastpk_ff) >= PEAK_W'(`RTDC_PEAK_DELTA)) begin
        nxt_chg = 1'b1;
      end
    end
    // verdict at the end of the interval
    if (run_ff && !sleep_ff && win_ff == CW'(DET_END - 1)) begin
      nxt_cont = nxt_chg;
    end
    if (!hot_ff) begin
      nxt_blk_cnt = '0;
      nxt_blk     = 1'b1;
    end else if (blk_cnt_ff >= CW'(BLINK_HALF - 1)) begin
      nxt_blk_cnt = '0;
      nxt_blk     = ~blk_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_ff   <= 1'b0;
      win_ff     <= '0;
      cont_ff    <= 1'b0;
      chg_ff     <= 1'b0;
      havepk_ff  <= 1'b0;
      lastpk_ff  <= '0;
      blk_cnt_ff <= '0;
      blk_ff     <= 1'b1;
    end else begin
      sleep_ff   <= nxt_sleep;
      win_ff     <= nxt_win;
      cont_ff    <= nxt_cont;
      chg_ff     <= nxt_chg;
      havepk_ff  <= nxt_havepk;
      lastpk_ff  <= nxt_lastpk;
      blk_cnt_ff <= nxt_blk_cnt;
      blk_ff     <= nxt_blk;
    end
  end

  // ----------------------------------------
  // gate drive sequencer
  // ----------------------------------------
  rtdc_drv_t     st_ff, nxt_st;
  logic [TW-1:0] t_ff, nxt_t;
  logic [TW-1:0] hold_ff, nxt_hold;
  logic          gate_ff, nxt_gate;
  logic          osc_en;

  // intermittent mode stays quiet in the sleep window
  assign osc_en = run_ff && !hot_ff && (cont_ff || !sleep_ff);

  always_comb begin
    nxt_st   = st_ff;
    nxt_t    = t_ff + TW'(1);
    nxt_hold = hold_ff;
    nxt_gate = 1'b0;
    case (st_ff)
      RTDC_ST_IDLE: begin
        nxt_t = '0;
        if (osc_en) begin
          nxt_st   = RTDC_ST_ON;
          nxt_gate = 1'b1;
        end
      end
      RTDC_ST_ON: begin
        nxt_gate = 1'b1;
        if (t_ff >= ton_cycles(on_time_resistor_value) - TW'(1)) begin
          nxt_st   = RTDC_ST_MEAS;
          nxt_t    = '0;
          nxt_gate = 1'b0;
        end
      end
      RTDC_ST_MEAS: begin
        if (ring_hi) begin
          nxt_st   = RTDC_ST_REST;
          nxt_hold = t_ff;
        end
      end
      RTDC_ST_REST: begin
        nxt_t = '0;
        if (!ring_hi) begin
          nxt_st = RTDC_ST_HOLD;
        end
      end
      RTDC_ST_HOLD: begin
        if (t_ff >= hold_ff) begin
          nxt_st   = RTDC_ST_ON;
          nxt_t    = '0;
          nxt_gate = 1'b1;
        end
      end
      default: begin
        nxt_st = RTDC_ST_IDLE;
      end
    endcase
    if (!osc_en) begin
      nxt_st   = RTDC_ST_IDLE;
      nxt_gate = 1'b0;
      nxt_t    = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff   <= RTDC_ST_IDLE;
      t_ff    <= '0;
      hold_ff <= '0;
      gate_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      t_ff    <= nxt_t;
      hold_ff <= nxt_hold;
      gate_ff <= nxt_gate;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic oe_ff, nxt_oe;

  always_comb begin
    if (stby_ff || !run_ff) begin
      nxt_oe = 1'b0;
    end else if (hot_ff) begin
      nxt_oe = blk_ff;
    end else begin
      nxt_oe = cont_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= nxt_oe;
    end
  end

  assign gate_drive_out = gate_ff;
  assign status_oe      = oe_ff;
  assign status_out     = 1'b0; // open drain: only ever pulls low

endmodule // rtdc_ctrl

//--- testbench/rtdc_ctrl_monitor.sv
`timescale 1ns/1ps
module rtdc_ctrl_monitor #(
  parameter int BLINK_HALF = 750000,
  parameter int START_CYC  = 10,
  parameter int RES_W      = 12
) (
  input wire logic             clk,
  input wire logic             resetn,
  input wire logic             uv_detect_in,
  input wire logic             uv_release_in,
  input wire logic             sense_above_supply_in,
  input wire logic             thermal_trip_in,
  input wire logic [RES_W-1:0] on_time_resistor_value,
  input wire logic             gate_drive_out,
  input wire logic             status_out,
  input wire logic             status_oe
);
  localparam int RISE_MAX = START_CYC + 12;
  int   hi_ff;
  int   run_ff;
  int   nchg_ff;
  int   ton;
  logic oe_ff;
  logic chg;
  // ----
  // helpers
  // ----
  // on-time in whole cycles, kiloohm input, rounded up
  assign ton = ((int'(on_time_resistor_value) * 3860 + 999) / 1000 + 179) / 40;
  assign chg = status_oe != oe_ff;
  // high length, blink spacing, blink edges seen while hot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_ff   <= 0;
      run_ff  <= 0;
      nchg_ff <= 0;
      oe_ff   <= 1'b0;
    end else begin
      hi_ff   <= gate_drive_out ? hi_ff + 1 : 0;
      run_ff  <= chg ? 1 : run_ff + 1;
      nchg_ff <= thermal_trip_in ? nchg_ff + int'(chg) : 0;
      oe_ff   <= status_oe;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // assertions
  // ----
  // input sync costs a few cycles, hence the repeat counts
  a_standby_low: assert property (uv_detect_in [*6] |-> !gate_drive_out && !status_oe)
    else $error("output active in standby");
  a_status_data: assert property (status_out == 1'b0)
    else $error("status data not low");
  a_ton_exact: assert property ($fell(gate_drive_out) && status_oe && !thermal_trip_in
    && !uv_detect_in |-> hi_ff == ton) else $error("on-time length wrong");
  a_ton_max: assert property (gate_drive_out && hi_ff == ton - 1 |=> !gate_drive_out)
    else $error("on-time overrun");
  a_hold_quiet: assert property ($rose(gate_drive_out) |->
    !$past(sense_above_supply_in) && !$past(sense_above_supply_in, 2))
    else $error("gate rose while tank rings");
  a_hot_low: assert property (thermal_trip_in [*6] |-> !gate_drive_out)
    else $error("gate high while hot");
  a_blink_step: assert property (thermal_trip_in && !uv_detect_in && chg && nchg_ff > 0
    |-> run_ff == BLINK_HALF) else $error("blink half period wrong");
  a_start_delay: assert property ($rose(uv_release_in) |-> (!gate_drive_out) [*8]
    ##[1:RISE_MAX] gate_drive_out) else $error("start-up delay wrong");
endmodule // rtdc_ctrl_monitor

//--- testbench/rtdc_tank_model.sv
`timescale 1ns/1ps
module rtdc_tank_model #(
  parameter int PEAK_W = 8
) (
  input  wire logic        clk,
  input  wire logic        gate_drive_out,
  input  wire logic        rx_present,
  output logic             sense_above_supply_in,
  output logic [PEAK_W-1:0] resonance_peak_in
);
  logic g_prev;
  int   dly;
  int   wid;
  // ring-down after each gate pulse; random delay and width give slow and prompt tanks
  initial begin
    sense_above_supply_in = 1'b0;
    resonance_peak_in = PEAK_W'(8'h80);
    g_prev = 1'b0;
    forever begin
      @(negedge clk);
      if (g_prev && !gate_drive_out) begin
        dly = 3 + $urandom % 10;
        wid = 3 + $urandom % 8;
        // a coupled receiver swings the peak; an empty pad repeats it
        if (!rx_present) resonance_peak_in = PEAK_W'(8'h80);
        else if (resonance_peak_in == PEAK_W'(8'h60)) resonance_peak_in = PEAK_W'(8'h70);
        else resonance_peak_in = PEAK_W'(8'h60);
        repeat (dly) @(negedge clk);
        sense_above_supply_in = 1'b1;
        repeat (wid) @(negedge clk);
        sense_above_supply_in = 1'b0;
      end
      g_prev = gate_drive_out;
    end
  end
endmodule // rtdc_tank_model

//--- testbench/rtdc_ctrl_tb_top.sv
`timescale 1ns/1ps
module rtdc_ctrl_tb_top;
  localparam int ACT = 2000;
  localparam int SLP = 4000;
  localparam int BLK = 300;
  localparam int ST  = 10;
  logic        clk, resetn, uv_detect_in, uv_release_in, sense_above_supply_in, thermal_trip_in;
  logic [7:0]  resonance_peak_in;
  logic [11:0] on_time_resistor_value;
  logic        gate_drive_out, status_out, status_oe, rx_present;
  wire         status_pin = status_oe ? status_out : 1'b1; // led pull-up
  int          error_cnt, total_checks, exp_q[$];
  int          o_hi, o_lo, o_oe, o_tog, hi_len, lo_len, t1, n, ton;
  int          t2 = -1;

  rtdc_ctrl #(.ACT_CYC(ACT), .SLEEP_CYC(SLP), .BLINK_HALF(BLK), .DET_START(1200),
    .DET_END(2000), .START_CYC(ST)) dut (.clk(clk), .resetn(resetn),
    .uv_detect_in(uv_detect_in), .uv_release_in(uv_release_in),
    .sense_above_supply_in(sense_above_supply_in), .thermal_trip_in(thermal_trip_in),
    .resonance_peak_in(resonance_peak_in), .on_time_resistor_value(on_time_resistor_value),
    .gate_drive_out(gate_drive_out), .status_out(status_out), .status_oe(status_oe));
  rtdc_tank_model u_tank (.clk(clk), .gate_drive_out(gate_drive_out), .rx_present(rx_present),
    .sense_above_supply_in(sense_above_supply_in), .resonance_peak_in(resonance_peak_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----
  // checking
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // tallies over a span: high cycles, longest low run, led-on cycles, led edges
  task automatic observe(input int cyc);
    int   run;
    logic p;
    {o_hi, o_lo, o_oe, o_tog, run} = 160'd0;
    p = status_pin;
    repeat (cyc) begin
      @(negedge clk);
      run = gate_drive_out ? 0 : run + 1;
      o_hi += int'(gate_drive_out);
      o_lo = run > o_lo ? run : o_lo;
      o_oe += int'(status_pin === 1'b0);
      o_tog += int'(status_pin !== p);
      p = status_pin;
    end
  endtask
  // bounded wait for the first gate pulse
  task automatic wait_rise(input int lim);
    n = 0;
    while (gate_drive_out !== 1'b1 && n <= lim) begin
      @(negedge clk);
      n++;
    end
    check("rise_seen", gate_drive_out, 1);
    if (n > lim) print_verdict();
  endtask
  // pulse watcher: pops one queued on-time per finished pulse; idle while queue empty
  always @(posedge clk) begin
    if (gate_drive_out) begin
      if (t2 >= 0 && exp_q.size() > 0) check("off_hold", 32'(t2 >= t1 - 2 && t2 <= t1 + 10), 1);
      hi_len++;
      lo_len = 0;
      t1 = 0;
      t2 = -1;
    end else begin
      if (hi_len > 0 && exp_q.size() > 0) check("on_time", hi_len, exp_q.pop_front());
      hi_len = 0;
      lo_len++;
      if (t2 >= 0) t2++;
      else if (t1 > 0 && !sense_above_supply_in) t2 = 0;
      if (sense_above_supply_in && t1 == 0) t1 = lo_len;
    end
  end
  // ----
  // stimulus
  // ----
  initial begin
    void'($urandom(99588));
    resetn = 1'b0;
    uv_detect_in = 1'b1;
    uv_release_in = 1'b0;
    thermal_trip_in = 1'b0;
    rx_present = 1'b0;
    on_time_resistor_value = 12'(500 + $urandom % 1501);
    ton = ((on_time_resistor_value * 3860 + 999) / 1000 + 179) / 40;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    // below detect, then between the two levels: no start
    observe(100);
    check("standby_gate", o_hi, 0);
    check("standby_led", o_oe, 0);
    uv_detect_in = 1'b0;
    observe(200);
    check("hyst_gate", o_hi, 0);
    uv_release_in = 1'b1;
    wait_rise(ST + 30);
    check("start_delay", 32'(n >= ST), 1);
    // empty pad: bursts only in the active window, led dark
    observe(2 * (ACT + SLP));
    check("sleep_gap", 32'(o_lo >= SLP), 1);
    check("idle_led", o_oe, 0);
    check("active_osc", 32'(o_hi > 0), 1);
    // receiver placed: peaks change, mode goes continuous
    rx_present = 1'b1;
    observe(2 * (ACT + SLP));
    repeat (20) exp_q.push_back(ton);
    observe(ACT + SLP);
    check("cont_led", o_oe, ACT + SLP);
    check("cont_gap", 32'(o_lo < 200), 1);
    check("pulses", exp_q.size(), 0);
    // receiver removed: peaks repeat, next verdict falls back to intermittent
    rx_present = 1'b0;
    observe(2 * (ACT + SLP));
    check("drop_gap", 32'(o_lo >= SLP), 1);
    observe(ACT + SLP);
    check("drop_led", o_oe, 0);
    // over-temperature: gate latched low, led blinks even after cooling
    // led was dark, so the first blink phase adds one extra edge
    thermal_trip_in = 1'b1;
    observe(4 * BLK + 20);
    check("hot_gate", 32'(o_hi <= 5), 1);
    check("blink", o_tog, 5);
    thermal_trip_in = 1'b0;
    observe(ACT + SLP);
    check("latch_gate", o_hi, 0);
    check("blink_on", o_tog, (ACT + SLP) / BLK);
    // supply dip clears the latch, release restarts
    uv_detect_in = 1'b1;
    uv_release_in = 1'b0;
    observe(20);
    check("uv_gate", gate_drive_out, 0);
    check("uv_led", status_pin, 1);
    uv_detect_in = 1'b0;
    uv_release_in = 1'b1;
    wait_rise(ST + 30);
    check("restart", 32'(n >= ST), 1);
    print_verdict();
  end
endmodule // rtdc_ctrl_tb_top

bind rtdc_ctrl rtdc_ctrl_monitor #(.BLINK_HALF(BLINK_HALF), .START_CYC(START_CYC), .RES_W(RES_W))
  u_mon (.clk(clk), .resetn(resetn), .uv_detect_in(uv_detect_in), .uv_release_in(uv_release_in),
  .sense_above_supply_in(sense_above_supply_in), .thermal_trip_in(thermal_trip_in),
  .on_time_resistor_value(on_time_resistor_value), .gate_drive_out(gate_drive_out),
  .status_out(status_out), .status_oe(status_oe));
